// >>> core/cca_div_pkg.sv
// Package for the channel assessment and antenna diversity block.
// Assumes an 8-bit register port and a 100 MHz core clock.
package cca_div_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] DECISION_SELECT_ADDR = 8'h00;
  localparam logic [7:0] BUSY_SOURCE_ADDR     = 8'h01;
  localparam logic [7:0] DWELL_PERIOD_ADDR    = 8'h02;
  localparam logic [7:0] BAUD_DELAY_ADDR      = 8'h03;
  localparam logic [7:0] RADIO_STATUS_ADDR    = 8'h04;
  localparam logic [7:0] LOCK_EVENT_ADDR      = 8'h05;
  localparam logic [7:0] CHANGE_EVENT_ADDR    = 8'h06;
  localparam logic [7:0] EVENT_MASK_ADDR      = 8'h07;
  localparam logic [7:0] STRENGTH_LIMIT_ADDR  = 8'h08;
  localparam logic [7:0] RECEIVE_CTRL_ADDR    = 8'h09;
  localparam logic [7:0] ACCEPT_CARRIER_ADDR  = 8'h0A;
  localparam logic [7:0] ACCEPT_LOCK_ADDR     = 8'h0B;
  localparam logic [7:0] BAUD_RATIO_ADDR      = 8'h0C;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int USE_SS_BIT    = 0;  // use_signal_strength
  localparam int USE_BAUD_BIT  = 1;  // use_baud_carrier
  localparam int USE_LOCK_BIT  = 2;  // use_baud_lock
  localparam int LOCK_EN_BIT   = 3;  // lock_enable
  localparam int ST_BUSY_BIT   = 0;  // radio status fields
  localparam int ST_LOCK_BIT   = 1;
  localparam int ST_ANT_BIT    = 2;
  localparam int ST_AUTO_BIT   = 3;
  localparam int ST_MAN_BIT    = 4;
  localparam int ST_ABOVE_BIT  = 5;
  localparam int RX_RESET_BIT  = 0;
  localparam int RX_START_BIT  = 1;
  localparam int EV_BUSY_FOUND = 0;  // flag vector positions
  localparam int EV_BUSY_CHG   = 1;
  localparam int EV_ANT_LOCK   = 2;
  localparam int EV_ANT_CHG    = 3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [3:0] DSEL_RST   = 4'h0;
  localparam logic [5:0] PERIOD_RST = 6'h00;
  localparam logic [5:0] DELAY_RST  = 6'h00;
  localparam logic [3:0] MASK_RST   = 4'hF;
  localparam logic [7:0] BYTE_RST   = 8'h00;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int DWELL_UNIT_NS  = 1000;   // One dwell tick
  localparam int DWELL_UNIT_CYC = DWELL_UNIT_NS / CLK_PERIOD_NS;
  localparam int PRE_W          = 7;
  localparam logic [PRE_W-1:0] PRE_LAST =
    PRE_W'(DWELL_UNIT_CYC - 1);
  localparam int SETTLE_CYC     = 3;      // Final calculation slot
  localparam logic [PRE_W-1:0] PRE_SETTLE =
    PRE_W'(DWELL_UNIT_CYC - SETTLE_CYC);

  // ----------------------------------------
  // Whole state of the block
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]       rdata;    // Read data, one cycle late
    logic [3:0]       dsel;     // Decision select
    logic             ext_sel;  // use_external_busy
    logic [5:0]       period;   // Dwell period
    logic [5:0]       delay;    // Baud start delay
    logic             auto_sw;  // auto_switch_control
    logic             manual;   // manual_antenna_choice
    logic [3:0]       flags;    // Sticky events
    logic [3:0]       mask;     // 1 = masked
    logic [7:0]       limit;    // Strength lower limit
    logic [7:0]       acc_cs;   // Accept count, carrier
    logic [7:0]       acc_sd;   // Accept count, lock
    logic [7:0]       ratio;    // Good/fail ratio
    logic [PRE_W-1:0] pre;      // Clocks within a tick
    logic [5:0]       unit;     // Ticks within a period
    logic             cs_dec;   // Baud carrier decision
    logic             sd_dec;   // Baud lock decision
    logic             ant;      // Antenna in use
    logic             locked;   // Switching stopped
    logic             busy_d;   // Previous busy
    logic             lock_d;   // Previous lock status
  } div_state_t;

endpackage : cca_div_pkg

// >>> core/cca_antenna_diversity.sv
// Clear channel assessment and automatic antenna diversity.
// Assumes synchronous inputs on core_clk_i and external baud
// counters that clear on measure_clear_o and count while
// measure_active_o is high.
`timescale 1ns/10ps
`default_nettype none

module cca_antenna_diversity #(
  parameter int CNT_W = 8       // Width of baud counts
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  // Register port
  input  wire logic [7:0]       addr_i,
  input  wire logic [7:0]       wr_data_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [7:0]       rd_data_o,
  // Transceiver side
  input  wire logic [7:0]       rssi_i,
  input  wire logic             ext_busy_in_i,
  input  wire logic [CNT_W-1:0] good_count_i,
  input  wire logic [CNT_W-1:0] fail_count_i,
  output logic                  measure_active_o,
  output logic                  measure_clear_o,
  // Antenna switch
  output logic                  antenna_select_out_o,
  output logic                  antenna_select_n_o,
  // Controller
  output logic                  channel_busy_o,
  output logic                  irq_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Baud verdict: good must beat the accept count and
  // also ratio times fail.
  function automatic logic baud_ok(
    input logic [CNT_W-1:0] good,
    input logic [CNT_W-1:0] fail,
    input logic [7:0]       accept,
    input logic [7:0]       ratio
  );
    logic [CNT_W+7:0] prod;
    logic [CNT_W+7:0] good_w;
    prod   = (CNT_W+8)'(fail) * (CNT_W+8)'(ratio);
    good_w = (CNT_W+8)'(good);
    return (good_w > (CNT_W+8)'(accept)) && (good_w > prod);
  endfunction : baud_ok

  // ----------------------------------------
  // State
  // ----------------------------------------
  // Timer step, sized to the prescaler
  localparam logic [cca_div_pkg::PRE_W-1:0] PRE_INC = {{(cca_div_pkg::PRE_W-1){1'h0}}, 1'h1};
  cca_div_pkg::div_state_t st_reg;  // Registered state
  cca_div_pkg::div_state_t st_next; // Next state

  logic above;       // Strength above limit
  logic busy_int;    // Internal assessment
  logic busy;        // Chosen busy result
  logic stop_div;    // Lock decision now
  logic tick_end;    // Last clock of a tick
  logic period_end;  // Last clock of a period
  logic running;     // Timer enabled
  logic restart;     // Receive reset or start written
  logic [3:0] ev_set;  // Events this cycle
  logic [3:0] ev_clr;  // Software clears

  // ----------------------------------------
  // Decisions
  // ----------------------------------------
  always_comb begin
    // Strength compare, strictly greater
    above = rssi_i > st_reg.limit;
    // Disabled inputs count as true
    busy_int =
      (!st_reg.dsel[cca_div_pkg::USE_BAUD_BIT] ||
       st_reg.cs_dec) &&
      (!st_reg.dsel[cca_div_pkg::USE_SS_BIT] ||
       above);
    // Source select
    if (st_reg.ext_sel) begin
      busy = ext_busy_in_i;
    end else begin
      busy = busy_int;
    end
    // The live decision feeds the status bit; the latch
    // in the next-state logic keeps the antenna fixed.
    // Lock decision, off unless lock_enable
    stop_div =
      st_reg.dsel[cca_div_pkg::LOCK_EN_BIT] &&
      (!st_reg.dsel[cca_div_pkg::USE_LOCK_BIT] ||
       st_reg.sd_dec) &&
      (!st_reg.dsel[cca_div_pkg::USE_SS_BIT] ||
       above);
  end

  // ----------------------------------------
  // Dwell timer flags
  // ----------------------------------------
  always_comb begin
    // Unit counts up to one below the period, so a period
    // of N ticks spans exactly N whole ticks.
    // A zero period holds the timer still
    running    = st_reg.period != 6'h00;
    tick_end   = st_reg.pre == cca_div_pkg::PRE_LAST;
    period_end = running && tick_end &&
                 (st_reg.unit == st_reg.period - 6'h01);
    restart    = wr_i &&
      (addr_i == cca_div_pkg::RECEIVE_CTRL_ADDR) &&
      (wr_data_i[cca_div_pkg::RX_RESET_BIT] ||
       wr_data_i[cca_div_pkg::RX_START_BIT]);
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    ev_set  = 4'h0;
    ev_clr  = 4'h0;

    // Dwell timer: runs and restarts each period
    if (restart) begin
      // Clear both counters to restart the period
      st_next.pre  = '0;
      st_next.unit = 6'h00;
    end else if (!running) begin
      st_next.pre  = '0;
      st_next.unit = 6'h00;
    end else if (tick_end) begin
      st_next.pre = '0;
      if (period_end) begin
        st_next.unit = 6'h00;
      end else begin
        st_next.unit = st_reg.unit + 6'h01;
      end
    end else begin
      st_next.pre = st_reg.pre + PRE_INC;
    end

    // Tallies are sampled on the edge that clears them
    // Baud verdicts, taken every period even when locked
    if (period_end) begin
      st_next.cs_dec = baud_ok(good_count_i, fail_count_i,
        st_reg.acc_cs, st_reg.ratio);
      st_next.sd_dec = baud_ok(good_count_i, fail_count_i,
        st_reg.acc_sd, st_reg.ratio);
    end

    // Restart wins over a true decision so testing resumes
    // Lock latch; receive reset or start resumes testing
    if (restart) begin
      st_next.locked = 1'b0;
    end else if (stop_div) begin
      st_next.locked = 1'b1;
    end

    // Antenna choice; no toggle while the decision is true,
    // so the antenna in use when the decision turns true is the one kept
    if (!st_reg.auto_sw) begin
      st_next.ant = st_reg.manual;
    end else if (period_end && !st_reg.locked && !stop_div) begin
      st_next.ant = !st_reg.ant;
    end

    // Edge history
    st_next.busy_d = busy;
    st_next.lock_d = stop_div;

    // Events; edges use the combinational busy, so the busy-found flag sets on the edge
    // channel_busy_o rises, and the busy-change flag on every edge it changes
    ev_set[cca_div_pkg::EV_BUSY_FOUND] =
      busy && !st_reg.busy_d;
    ev_set[cca_div_pkg::EV_BUSY_CHG] =
      busy != st_reg.busy_d;
    ev_set[cca_div_pkg::EV_ANT_LOCK] =
      stop_div && !st_reg.lock_d;
    ev_set[cca_div_pkg::EV_ANT_CHG] =
      st_next.ant != st_reg.ant;

    // Register writes
    if (wr_i) begin
      unique case (addr_i)
        cca_div_pkg::DECISION_SELECT_ADDR: begin
          st_next.dsel = wr_data_i[3:0];
        end
        cca_div_pkg::BUSY_SOURCE_ADDR: begin
          st_next.ext_sel = wr_data_i[0];
        end
        cca_div_pkg::DWELL_PERIOD_ADDR: begin
          st_next.period = wr_data_i[5:0];
        end
        cca_div_pkg::BAUD_DELAY_ADDR: begin
          st_next.delay = wr_data_i[5:0];
        end
        cca_div_pkg::RADIO_STATUS_ADDR: begin
          // Only the two control bits are writable
          st_next.auto_sw =
            wr_data_i[cca_div_pkg::ST_AUTO_BIT];
          st_next.manual =
            wr_data_i[cca_div_pkg::ST_MAN_BIT];
        end
        cca_div_pkg::LOCK_EVENT_ADDR: begin
          // Write one to clear
          ev_clr[cca_div_pkg::EV_BUSY_FOUND] = wr_data_i[0];
          ev_clr[cca_div_pkg::EV_ANT_LOCK]   = wr_data_i[1];
        end
        cca_div_pkg::CHANGE_EVENT_ADDR: begin
          ev_clr[cca_div_pkg::EV_BUSY_CHG] = wr_data_i[0];
          ev_clr[cca_div_pkg::EV_ANT_CHG]  = wr_data_i[1];
        end
        cca_div_pkg::EVENT_MASK_ADDR: begin
          st_next.mask = wr_data_i[3:0];
        end
        cca_div_pkg::STRENGTH_LIMIT_ADDR: begin
          st_next.limit = wr_data_i;
        end
        cca_div_pkg::ACCEPT_CARRIER_ADDR: begin
          st_next.acc_cs = wr_data_i;
        end
        cca_div_pkg::ACCEPT_LOCK_ADDR: begin
          st_next.acc_sd = wr_data_i;
        end
        cca_div_pkg::BAUD_RATIO_ADDR: begin
          st_next.ratio = wr_data_i;
        end
        default: begin
          // Unmapped or pulse-only: nothing stored
        end
      endcase
    end

    // A new event beats a clear in the same cycle
    st_next.flags = (st_reg.flags & ~ev_clr) | ev_set;

    // Read data, valid the cycle after the strobe; status
    // bits are live, as of the cycle the strobe is taken
    st_next.rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        cca_div_pkg::DECISION_SELECT_ADDR: begin
          st_next.rdata = {4'h0, st_reg.dsel};
        end
        cca_div_pkg::BUSY_SOURCE_ADDR: begin
          st_next.rdata = {7'h00, st_reg.ext_sel};
        end
        cca_div_pkg::DWELL_PERIOD_ADDR: begin
          st_next.rdata = {2'h0, st_reg.period};
        end
        cca_div_pkg::BAUD_DELAY_ADDR: begin
          st_next.rdata = {2'h0, st_reg.delay};
        end
        cca_div_pkg::RADIO_STATUS_ADDR: begin
          st_next.rdata = {2'h0,
            above,
            st_reg.manual,
            st_reg.auto_sw,
            st_reg.ant,
            stop_div,
            busy};
        end
        cca_div_pkg::LOCK_EVENT_ADDR: begin
          st_next.rdata = {6'h00,
            st_reg.flags[cca_div_pkg::EV_ANT_LOCK],
            st_reg.flags[cca_div_pkg::EV_BUSY_FOUND]};
        end
        cca_div_pkg::CHANGE_EVENT_ADDR: begin
          st_next.rdata = {6'h00,
            st_reg.flags[cca_div_pkg::EV_ANT_CHG],
            st_reg.flags[cca_div_pkg::EV_BUSY_CHG]};
        end
        cca_div_pkg::EVENT_MASK_ADDR: begin
          st_next.rdata = {4'h0, st_reg.mask};
        end
        cca_div_pkg::STRENGTH_LIMIT_ADDR: begin
          st_next.rdata = st_reg.limit;
        end
        cca_div_pkg::ACCEPT_CARRIER_ADDR: begin
          st_next.rdata = st_reg.acc_cs;
        end
        cca_div_pkg::ACCEPT_LOCK_ADDR: begin
          st_next.rdata = st_reg.acc_sd;
        end
        cca_div_pkg::BAUD_RATIO_ADDR: begin
          st_next.rdata = st_reg.ratio;
        end
        default: begin
          // Unmapped and receive control read as zero
          st_next.rdata = 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      // Hard or soft reset also drops the lock; masks come
      // up set so nothing interrupts before firmware is ready
      st_reg         <= '0;
      st_reg.dsel    <= cca_div_pkg::DSEL_RST;
      st_reg.period  <= cca_div_pkg::PERIOD_RST;
      st_reg.delay   <= cca_div_pkg::DELAY_RST;
      st_reg.mask    <= cca_div_pkg::MASK_RST;
      st_reg.limit   <= cca_div_pkg::BYTE_RST;
      st_reg.auto_sw <= 1'b1;   // Automatic after reset
      st_reg.busy_d  <= 1'b1;   // Matches busy with all off
    end else begin
      st_next_q: st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Measurement window: after the settling delay and
  // before the last few clocks kept for calculation.
  always_comb begin
    measure_active_o = running && !restart &&
      (st_reg.unit >= st_reg.delay) &&
      !((st_reg.unit == st_reg.period - 6'h01) &&
        (st_reg.pre >= cca_div_pkg::PRE_SETTLE));
    measure_clear_o = period_end || restart;
  end

  // Both select lines come from one flop, so they can
  // never overlap or both sit low during a switch
  // Complementary antenna pair
  assign antenna_select_out_o = st_reg.ant;
  assign antenna_select_n_o   = !st_reg.ant;
  assign rd_data_o            = st_reg.rdata;
  // Busy only reported; no transmit path looks at it
  assign channel_busy_o       = st_reg.busy_d;
  assign irq_o = |(st_reg.flags & ~st_reg.mask);

endmodule : cca_antenna_diversity

`default_nettype wire

// >>> testbench/cca_div_checker.sv
// Port-level checker for the assessment and diversity block.
// Assumes it is bound to the block; mirrors the settings written.
`timescale 1ns/10ps
`default_nettype none

module cca_div_checker (
  // Clock and reset
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rd_data_o,
  // Radio, antenna and controller
  input wire logic [7:0] rssi_i,
  input wire logic       ext_busy_in_i,
  input wire logic       antenna_select_out_o,
  input wire logic       antenna_select_n_o,
  input wire logic       channel_busy_o,
  input wire logic       irq_o
);
  // ----
  // Setting mirrors
  // ----
  logic       ext_q;    // Busy taken from the pin
  logic [1:0] sel_q;    // Busy input enables
  logic [7:0] limit_q;  // Strength lower limit
  logic [3:0] mask_q;   // Event masks, 1 = masked
  logic       above;    // Strict compare, as the block does
  logic       ss_cfg;   // Strength alone decides busy
  logic       none_cfg; // No input enabled
  assign above    = rssi_i > limit_q;
  assign ss_cfg   = !ext_q && sel_q == 2'b01;
  assign none_cfg = !ext_q && sel_q == 2'b00;
  // Mirrors follow writes on the same edge as the block
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ext_q   <= 1'b0;
      sel_q   <= 2'b00;
      limit_q <= 8'h00;
      mask_q  <= 4'hF;
    end else if (wr_i) begin
      if (addr_i == cca_div_pkg::BUSY_SOURCE_ADDR) ext_q <= wr_data_i[0];
      if (addr_i == cca_div_pkg::DECISION_SELECT_ADDR) sel_q <= wr_data_i[1:0];
      if (addr_i == cca_div_pkg::STRENGTH_LIMIT_ADDR) limit_q <= wr_data_i;
      if (addr_i == cca_div_pkg::EVENT_MASK_ADDR) mask_q <= wr_data_i[3:0];
    end
  end
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Busy rises while its event may interrupt
  sequence busy_rise_open;
    !channel_busy_o ##1 (channel_busy_o && !mask_q[0]);
  endsequence
  chk_ant_complement: assert property (antenna_select_n_o == !antenna_select_out_o)
    else $error("antenna pair not complementary");
  chk_read_idle: assert property (!$past(rd_i) |-> rd_data_o == 8'h00)
    else $error("read data outside its cycle");
  chk_mask_read: assert property (rd_i && addr_i == cca_div_pkg::EVENT_MASK_ADDR |=> rd_data_o == {4'h0, mask_q})
    else $error("mask read back wrong");
  chk_busy_pin: assert property (ext_q && $past(ext_q) |-> channel_busy_o == $past(ext_busy_in_i))
    else $error("busy does not follow pin");
  chk_busy_strength: assert property (ss_cfg && $past(ss_cfg) |-> channel_busy_o == $past(above))
    else $error("busy does not follow strength");
  chk_busy_none: assert property (none_cfg && $past(none_cfg) |-> channel_busy_o)
    else $error("busy low with no input enabled");
  chk_found_irq: assert property (busy_rise_open |-> irq_o)
    else $error("busy rise without request");
  chk_change_irq: assert property ($changed(channel_busy_o) && !mask_q[1] |-> irq_o)
    else $error("busy change without request");
  chk_antenna_change_flag_irq: assert property ($changed(antenna_select_out_o) && !mask_q[3] |-> irq_o)
    else $error("antenna change without request");
  chk_masked_quiet: assert property (mask_q == 4'hF |-> !irq_o)
    else $error("request while all masked");
endmodule : cca_div_checker
`default_nettype wire

// >>> testbench/cca_radio_model.sv
// Transceiver model: baud pass and fail tallies.
// Assumes the block clears the tallies and opens the window.
`timescale 1ns/10ps
`default_nettype none

module cca_radio_model (
  // Clock
  input  wire logic       core_clk_i,
  // Window control from the block
  input  wire logic       measure_active_i,
  input  wire logic       measure_clear_i,
  // Clean carrier when high, noise when low
  input  wire logic       good_mode_i,
  // Tallies to the block
  output var  logic [7:0] good_count_o,
  output var  logic [7:0] fail_count_o
);
  // Start from empty so the block never sees unknown tallies
  initial begin
    good_count_o = 8'h00;
    fail_count_o = 8'h00;
  end
  // Count one edge pair per open cycle; 97 at most here, no wrap
  always @(posedge core_clk_i) begin
    if (measure_clear_i) begin
      good_count_o <= 8'h00;
      fail_count_o <= 8'h00;
    end else if (measure_active_i && good_mode_i) begin
      good_count_o <= good_count_o + 8'h01;
    end else if (measure_active_i) begin
      fail_count_o <= fail_count_o + 8'h01;
    end
  end
endmodule : cca_radio_model
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the assessment and diversity block.
// Assumes the package, design, model and checker compile first.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  // ----
  // Signals
  // ----
  logic       core_clk_i, rst_i, wr_i, rd_i, ext_busy_in_i, good_mode;
  logic       measure_active_o, measure_clear_o, channel_busy_o, irq_o;
  logic       antenna_select_out_o, antenna_select_n_o, ant;
  logic [7:0] addr_i, wr_data_i, rd_data_o, rssi_i, good_count, fail_count, rv;
  int         num_errors, n_compared, cnt, act;

  cca_antenna_diversity #(.CNT_W(8)) cca_antenna_diversity_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .rssi_i(rssi_i),
    .ext_busy_in_i(ext_busy_in_i), .good_count_i(good_count), .fail_count_i(fail_count),
    .measure_active_o(measure_active_o), .measure_clear_o(measure_clear_o),
    .antenna_select_out_o(antenna_select_out_o), .antenna_select_n_o(antenna_select_n_o),
    .channel_busy_o(channel_busy_o), .irq_o(irq_o));
  cca_radio_model cca_radio_model_inst (
    .core_clk_i(core_clk_i), .measure_active_i(measure_active_o),
    .measure_clear_i(measure_clear_o), .good_mode_i(good_mode),
    .good_count_o(good_count), .fail_count_o(fail_count));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // ----
  // Shared tasks
  // ----
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : check
  task automatic test_done();
    $display("compares %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  // One-cycle write; a gap cycle follows, so no strobe is set twice at one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge core_clk_i);
    wr_i      <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i   <= 1'b0;
    @(negedge core_clk_i);
    rv = rd_data_o;
  endtask : rd
  // Bounded wait for the period-end pulse
  task automatic wait_clear();
    for (int i = 0; i < 1000; i++) begin
      @(negedge core_clk_i);
      if (measure_clear_o === 1'b1) return;
    end
    check(8'h00, 8'h01);
    test_done();
  endtask : wait_clear
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    rd(cca_div_pkg::RADIO_STATUS_ADDR);
    check(rv, 8'h09);
    check({6'h00, antenna_select_out_o, antenna_select_n_o}, 8'h01);
    check({7'h00, irq_o}, 8'h00);
    rd(cca_div_pkg::EVENT_MASK_ADDR);
    check(rv, 8'h0F);
    rd(8'h3C);
    check(rv, 8'h00);
    $display("reset test done");
  endtask : t_reset
  task automatic t_strength();
    wr(cca_div_pkg::STRENGTH_LIMIT_ADDR, 8'h40);
    wr(cca_div_pkg::DECISION_SELECT_ADDR, 8'h01);
    @(posedge core_clk_i) rssi_i <= 8'h40;
    rd(cca_div_pkg::RADIO_STATUS_ADDR);
    check(rv, 8'h08);
    @(posedge core_clk_i) rssi_i <= 8'h41;
    rd(cca_div_pkg::RADIO_STATUS_ADDR);
    check(rv, 8'h29);
    check({7'h00, channel_busy_o}, 8'h01);
    $display("strength test done");
  endtask : t_strength
  task automatic t_events();
    @(posedge core_clk_i) ext_busy_in_i <= 1'b0;
    wr(cca_div_pkg::BUSY_SOURCE_ADDR, 8'h01);
    wr(cca_div_pkg::LOCK_EVENT_ADDR, 8'h03);
    wr(cca_div_pkg::CHANGE_EVENT_ADDR, 8'h03);
    wr(cca_div_pkg::EVENT_MASK_ADDR, 8'h0C);
    @(negedge core_clk_i);
    check({7'h00, irq_o}, 8'h00);
    @(posedge core_clk_i) ext_busy_in_i <= 1'b1;
    repeat (3) @(negedge core_clk_i);
    check({6'h00, channel_busy_o, irq_o}, 8'h03);
    rd(cca_div_pkg::LOCK_EVENT_ADDR);
    check(rv, 8'h01);
    rd(cca_div_pkg::CHANGE_EVENT_ADDR);
    check(rv, 8'h01);
    wr(cca_div_pkg::LOCK_EVENT_ADDR, 8'h01);
    wr(cca_div_pkg::CHANGE_EVENT_ADDR, 8'h01);
    @(negedge core_clk_i);
    check({7'h00, irq_o}, 8'h00);
    @(posedge core_clk_i) ext_busy_in_i <= 1'b0;
    rd(cca_div_pkg::LOCK_EVENT_ADDR);
    check(rv, 8'h00);
    rd(cca_div_pkg::CHANGE_EVENT_ADDR);
    check({rv[6:0], irq_o}, 8'h03);
    wr(cca_div_pkg::CHANGE_EVENT_ADDR, 8'h01);
    wr(cca_div_pkg::EVENT_MASK_ADDR, 8'h0F);
    wr(cca_div_pkg::BUSY_SOURCE_ADDR, 8'h00);
    $display("event test done");
  endtask : t_events
  task automatic t_dwell();
    @(posedge core_clk_i) rssi_i <= 8'h00;
    wr(cca_div_pkg::DECISION_SELECT_ADDR, 8'h00);
    wr(cca_div_pkg::BAUD_DELAY_ADDR, 8'h01);
    wr(cca_div_pkg::CHANGE_EVENT_ADDR, 8'h03);
    wr(cca_div_pkg::DWELL_PERIOD_ADDR, 8'h02);
    wait_clear();
    ant = antenna_select_out_o;
    cnt = 0;
    act = 0;
    // Count one whole period and its open window
    do begin
      @(negedge core_clk_i);
      cnt++;
      if (cnt == 1) check({6'h00, antenna_select_out_o, antenna_select_n_o}, {6'h00, !ant, ant});
      if (measure_active_o === 1'b1) act++;
    end while (measure_clear_o !== 1'b1 && cnt < 1000);
    check(cnt[7:0], 8'hC8);
    check(act[7:0], 8'h61);
    if (cnt >= 1000) test_done();
    rd(cca_div_pkg::CHANGE_EVENT_ADDR);
    check(rv, 8'h02);
    $display("dwell test done");
  endtask : t_dwell
  task automatic t_lock();
    @(posedge core_clk_i) rssi_i <= 8'h41;
    wr(cca_div_pkg::LOCK_EVENT_ADDR, 8'h03);
    wr(cca_div_pkg::DECISION_SELECT_ADDR, 8'h09);
    rd(cca_div_pkg::RADIO_STATUS_ADDR);
    check(rv & 8'h22, 8'h22);
    rd(cca_div_pkg::LOCK_EVENT_ADDR);
    check(rv, 8'h02);
    wait_clear();
    ant = antenna_select_out_o;
    @(posedge core_clk_i) rssi_i <= 8'h00;
    wait_clear();
    @(negedge core_clk_i);
    check({7'h00, antenna_select_out_o}, {7'h00, ant});
    wr(cca_div_pkg::RECEIVE_CTRL_ADDR, 8'h01);
    wait_clear();
    @(negedge core_clk_i);
    check({7'h00, antenna_select_out_o}, {7'h00, !ant});
    $display("lock test done");
  endtask : t_lock
  // Two period ends pass so a whole window sees the new carrier
  task automatic t_baud(input logic g, input logic [7:0] acc, input logic exp);
    wr(cca_div_pkg::ACCEPT_CARRIER_ADDR, acc);
    @(posedge core_clk_i) good_mode <= g;
    wait_clear();
    wait_clear();
    repeat (2) @(negedge core_clk_i);
    check({7'h00, channel_busy_o}, {7'h00, exp});
  endtask : t_baud
  task automatic t_manual();
    wr(cca_div_pkg::DWELL_PERIOD_ADDR, 8'h00);
    wr(cca_div_pkg::RADIO_STATUS_ADDR, 8'h10);
    cnt = 0;
    repeat (300) begin
      @(negedge core_clk_i);
      if (measure_clear_o !== 1'b0) cnt++;
    end
    check(cnt[7:0], 8'h00);
    rd(cca_div_pkg::RADIO_STATUS_ADDR);
    check(rv & 8'h1C, 8'h14);
    wr(cca_div_pkg::RADIO_STATUS_ADDR, 8'h00);
    rd(cca_div_pkg::RADIO_STATUS_ADDR);
    check(rv & 8'h1C, 8'h00);
    $display("manual test done");
  endtask : t_manual
  // ----
  // Main sequence
  // ----
  initial begin
    rst_i = 1'b1;
    addr_i = 8'h00;
    wr_data_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    rssi_i = 8'h00;
    ext_busy_in_i = 1'b0;
    good_mode = 1'b0;
    num_errors = 0;
    n_compared = 0;
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_strength();
    t_events();
    t_dwell();
    t_lock();
    wr(cca_div_pkg::DECISION_SELECT_ADDR, 8'h0A);
    wr(cca_div_pkg::BAUD_RATIO_ADDR, 8'h01);
    t_baud(1'b0, 8'h05, 1'b0);
    t_baud(1'b1, 8'h05, 1'b1);
    t_baud(1'b1, 8'hFF, 1'b0);
    $display("baud test done");
    t_manual();
    test_done();
  end
endmodule : tb_top

bind cca_antenna_diversity cca_div_checker cca_div_checker_inst (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
  .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .rssi_i(rssi_i),
  .ext_busy_in_i(ext_busy_in_i), .antenna_select_out_o(antenna_select_out_o),
  .antenna_select_n_o(antenna_select_n_o), .channel_busy_o(channel_busy_o), .irq_o(irq_o));
`default_nettype wire
